//--- hw/power_mode_pkg.sv
// Constants, register map and state codes of the power mode sequencer.
package power_mode_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] control_offset = 8'h00;
  localparam logic [7:0] status_offset = 8'h04;
  localparam logic [7:0] wake_enable_offset = 8'h08;
  localparam logic [7:0] lifetime_offset = 8'h0c;
  localparam logic [7:0] peripheral_offset = 8'h10;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int mode_lsb = 0;
  localparam int cranking_enable_bit = 2;
  localparam int wake_source_count = 6;
  localparam int lifetime_wake_bit = 6;
  localparam int undervoltage_flag_bit = 7;
  localparam int mcu_power_on_bit = 8;
  localparam int analog_power_on_bit = 9;
  localparam int external_reset_bit = 10;
  localparam int state_lsb = 12;
  localparam int status_width = 16;

  // ----------------------------------------------------------------------
  // Mode field encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] mode_normal = 2'h0;
  localparam logic [1:0] mode_stop = 2'h1;
  localparam logic [1:0] mode_sleep = 2'h2;
  localparam logic [1:0] mode_unused = 2'h3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] control_reset = 3'h0;
  localparam logic [6:0] wake_enable_reset = 7'h00;
  localparam logic [15:0] peripheral_reset = 16'h0000;
  localparam logic [7:0] status_low_reset = 8'h00;
  localparam logic [2:0] cause_reset = 3'h2;

  // ----------------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------------
  localparam int sync_width = 7 + wake_source_count;
  localparam int lifetime_width = 32;

  typedef enum logic [3:0] {
    st_reset = 4'h0,
    st_normal = 4'h1,
    st_stop_wait = 4'h2,
    st_stop = 4'h3,
    st_sleep = 4'h4,
    st_wake_ramp = 4'h5,
    st_intermediate = 4'h6,
    st_cranking = 4'h7
  } op_state_t;

endpackage : power_mode_pkg

//--- hw/input_synchronizer.sv
// Two-stage synchroniser for a group of asynchronous level inputs.
`timescale 1ns/1ps
module input_synchronizer #(
  parameter int width = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);

  logic [width-1:0] first_stage;

  // The first stage feeds only the second; nothing else looks at it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_stage <= '0;
      sync_out <= '0;
    end else begin
      first_stage <= async_in;
      sync_out <= first_stage;
    end
  end

endmodule : input_synchronizer

//--- hw/lifetime_counter.sv
// Free-running lifetime counter with an overflow pulse.
`timescale 1ns/1ps
module lifetime_counter #(
  parameter int width = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  output logic [width-1:0] count,
  output logic overflow
);

  wire at_top = &count;

  // Counting continues in every mode except Reset (held clear), low-power modes included.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      overflow <= 1'b0;
    end else if (clear) begin
      count <= '0;
      overflow <= 1'b0;
    end else begin
      count <= count + 1'b1;
      overflow <= at_top;
    end
  end

endmodule : lifetime_counter

//--- hw/power_mode_sequencer.sv
// Operating mode, reset and regulator sequencer with an APB register port.
//
// Operation
// - Supply below POR threshold sets power-on flag.
// - Any reset condition: Reset mode, MCU reset low.
// - Entering Reset mode restores register defaults.
// - Last reset cause kept in status upper byte.
// - Wake-up stops in intermediate mode, low-power clock.
// - Writing 00 moves intermediate mode to Normal.
// - Lifetime counter runs, overflow wakes device.
// - Wake-up resets the window watchdog.
// - Writing 10 enters Sleep, supplies off.
// - Sleep wake: regulators on, release reset, flag.
// - Writing 01 enters Stop after link clock stops.
// - Serial and timer registers read-only during Stop.
// - Stop wake: main regulator, wake interrupt, flag.
// - Writing 00 before link clock stops returns to Normal.
// - Undervoltage interrupt; cranking threshold when enabled.
// - Interface regulator off in low power; digital on.
// - Cranking return flags undervoltage, stays intermediate.
`timescale 1ns/1ps
module power_mode_sequencer #(
  parameter int wake_sources = power_mode_pkg::wake_source_count,
  parameter int lifetime_bits = power_mode_pkg::lifetime_width
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mcu_supply_low,
  input wire logic digital_supply_low,
  input wire logic external_reset_request,
  input wire logic battery_below_undervoltage,
  input wire logic battery_below_cranking,
  input wire logic regulators_ready,
  input wire logic die_link_clock_stopped,
  input wire logic [wake_sources-1:0] wake_request,
  output logic mcu_reset_n,
  output logic mcu_supply_enable,
  output logic mcu_supply_from_main,
  output logic interface_supply_enable,
  output logic analog_supply_enable,
  output logic permanent_digital_supply_enable,
  output logic low_power_clock_select,
  output logic die_link_wake_interrupt,
  output logic undervoltage_interrupt,
  output logic watchdog_reset
);

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  localparam int sw = 7 + wake_sources;
  logic [sw-1:0] sync_in;
  wire [sw-1:0] raw_in = {wake_request, die_link_clock_stopped,
                          regulators_ready, battery_below_cranking,
                          battery_below_undervoltage, external_reset_request,
                          digital_supply_low, mcu_supply_low};

  input_synchronizer #(.width(sw)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  wire mcu_low = sync_in[0];
  wire digital_low = sync_in[1];
  wire ext_reset = sync_in[2];
  wire below_uv = sync_in[3];
  wire below_crank = sync_in[4];
  wire regs_ok = sync_in[5];
  wire link_stopped = sync_in[6];
  wire [wake_sources-1:0] wake_in = sync_in[sw-1:7];

  // ----------------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------------
  power_mode_pkg::op_state_t state;
  power_mode_pkg::op_state_t next_state;
  logic [2:0] control;
  logic [6:0] wake_enable;
  logic [7:0] status_low;
  logic [2:0] cause;
  logic [15:0] peripheral;
  logic regs_locked;
  logic from_stop;
  logic [lifetime_bits-1:0] lifetime_count;
  logic lifetime_overflow;

  function automatic logic is_low_power(power_mode_pkg::op_state_t s);
    return s == power_mode_pkg::st_stop || s == power_mode_pkg::st_sleep ||
           s == power_mode_pkg::st_cranking;
  endfunction : is_low_power

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire hit_control = paddr == power_mode_pkg::control_offset;
  wire hit_status = paddr == power_mode_pkg::status_offset;
  wire hit_wake = paddr == power_mode_pkg::wake_enable_offset;
  wire hit_life = paddr == power_mode_pkg::lifetime_offset;
  wire hit_periph = paddr == power_mode_pkg::peripheral_offset;
  wire mapped = hit_control || hit_status || hit_wake || hit_life ||
                hit_periph;
  wire wr = access && pwrite && mapped;
  wire [1:0] wr_mode = pwdata[power_mode_pkg::mode_lsb +: 2];
  wire mode_write = wr && hit_control;
  wire status_clear = wr && hit_status;

  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // ----------------------------------------------------------------------
  // Reset conditions and wake events
  // ----------------------------------------------------------------------
  wire reset_cond = mcu_low || digital_low || ext_reset;
  wire cranking_on = control[power_mode_pkg::cranking_enable_bit];
  wire uv_event = cranking_on ? below_crank : below_uv;
  wire [wake_sources-1:0] armed_wake =
    wake_in & wake_enable[wake_sources-1:0];
  wire life_wake =
    lifetime_overflow && wake_enable[power_mode_pkg::lifetime_wake_bit];
  wire any_wake = (|armed_wake) || life_wake;
  wire low_power = is_low_power(state);
  wire wake_start = (state == power_mode_pkg::st_stop ||
                     state == power_mode_pkg::st_sleep) && any_wake;
  wire crank_enter = state == power_mode_pkg::st_stop && cranking_on &&
                     below_crank;
  wire crank_exit = state == power_mode_pkg::st_cranking && !below_crank;
  wire ramp_done = state == power_mode_pkg::st_wake_ramp && regs_ok;
  // Reset mode entry returns all registers except the reset cause to defaults.
  wire reg_clear = reset_cond || state == power_mode_pkg::st_reset;

  // ----------------------------------------------------------------------
  // Mode sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      power_mode_pkg::st_reset: begin
        if (!reset_cond) begin
          next_state = power_mode_pkg::st_normal;
        end
      end
      power_mode_pkg::st_normal, power_mode_pkg::st_intermediate: begin
        if (mode_write) begin
          case (wr_mode)
            power_mode_pkg::mode_normal:
              next_state = power_mode_pkg::st_normal;
            power_mode_pkg::mode_stop:
              next_state = power_mode_pkg::st_stop_wait;
            power_mode_pkg::mode_sleep:
              next_state = power_mode_pkg::st_sleep;
            default: next_state = state;
          endcase
        end
      end
      power_mode_pkg::st_stop_wait: begin
        if (mode_write && wr_mode == power_mode_pkg::mode_normal) begin
          next_state = power_mode_pkg::st_normal;
        end else if (link_stopped) begin
          next_state = power_mode_pkg::st_stop;
        end
      end
      power_mode_pkg::st_stop: begin
        if (crank_enter) begin
          next_state = power_mode_pkg::st_cranking;
        end else if (any_wake) begin
          next_state = power_mode_pkg::st_wake_ramp;
        end
      end
      power_mode_pkg::st_sleep: begin
        if (any_wake) begin
          next_state = power_mode_pkg::st_wake_ramp;
        end
      end
      power_mode_pkg::st_wake_ramp: begin
        if (regs_ok) begin
          next_state = power_mode_pkg::st_intermediate;
        end
      end
      power_mode_pkg::st_cranking: begin
        if (!below_crank) begin
          next_state = power_mode_pkg::st_intermediate;
        end
      end
      default: next_state = power_mode_pkg::st_reset;
    endcase
    if (reset_cond) begin
      next_state = power_mode_pkg::st_reset;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= power_mode_pkg::st_reset;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      from_stop <= 1'b0;
    end else if (wake_start) begin
      from_stop <= state == power_mode_pkg::st_stop;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  // Encoding 11 leaves the stored mode field untouched as well.
  wire keep_mode = wr_mode == power_mode_pkg::mode_unused;
  wire [2:0] control_wdata = {pwdata[power_mode_pkg::cranking_enable_bit],
                              keep_mode ? control[1:0] : wr_mode};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= power_mode_pkg::control_reset;
      wake_enable <= power_mode_pkg::wake_enable_reset;
    end else if (reg_clear) begin
      control <= power_mode_pkg::control_reset;
      wake_enable <= power_mode_pkg::wake_enable_reset;
    end else begin
      if (mode_write) begin
        control <= control_wdata;
      end
      if (wr && hit_wake) begin
        wake_enable <= pwdata[6:0];
      end
    end
  end

  // The serial and timer shadow is locked from the Stop command until
  // Normal mode, so a stalled MCU cannot corrupt it.
  wire lock_set = mode_write && wr_mode == power_mode_pkg::mode_stop;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regs_locked <= 1'b0;
    end else if (reg_clear || next_state == power_mode_pkg::st_normal) begin
      regs_locked <= 1'b0;
    end else if (lock_set) begin
      regs_locked <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral <= power_mode_pkg::peripheral_reset;
    end else if (reg_clear) begin
      peripheral <= power_mode_pkg::peripheral_reset;
    end else if (wr && hit_periph && !regs_locked) begin
      peripheral <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  logic [wake_sources-1:0] wake_hold;
  logic life_wake_hold;
  // A flag set in the same cycle as its write-one clear stays set.
  wire [7:0] status_set = {uv_event || crank_exit,
                           ramp_done ? (life_wake_hold) : 1'b0,
                           ramp_done ? wake_hold : '0};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_hold <= '0;
      life_wake_hold <= 1'b0;
    end else if (wake_start) begin
      wake_hold <= armed_wake;
      life_wake_hold <= life_wake;
    end
  end

  wire [7:0] status_wclr = status_clear ? pwdata[7:0] : 8'h00;
  wire [2:0] cause_wclr = status_clear ? pwdata[10:8] : 3'h0;
  wire [2:0] cause_set = {ext_reset, digital_low, mcu_low};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_low <= power_mode_pkg::status_low_reset;
      cause <= power_mode_pkg::cause_reset;
    end else begin
      if (reg_clear) begin
        status_low <= power_mode_pkg::status_low_reset;
      end else begin
        status_low <= (status_low & ~status_wclr) | status_set;
      end
      // The cause survives Reset mode so software can read it later.
      if (reset_cond) begin
        cause <= cause_set;
      end else begin
        cause <= cause & ~cause_wclr;
      end
    end
  end

  lifetime_counter #(.width(lifetime_bits)) u_lifetime (
    .pclk(pclk),
    .presetn(presetn),
    .clear(reg_clear),
    .count(lifetime_count),
    .overflow(lifetime_overflow)
  );

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  wire [15:0] status_word = {state, 1'b0, cause, status_low};
  wire [31:0] rd_mux =
    hit_control ? {29'h0, control} :
    hit_status ? {16'h0, status_word} :
    hit_wake ? {25'h0, wake_enable} :
    hit_life ? 32'(lifetime_count) :
    hit_periph ? {16'h0, peripheral} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // Supplies, clocks and event outputs
  // ----------------------------------------------------------------------
  wire wake_out = ramp_done && from_stop;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      die_link_wake_interrupt <= 1'b0;
      watchdog_reset <= 1'b0;
    end else begin
      die_link_wake_interrupt <= wake_out;
      watchdog_reset <= wake_start;
    end
  end

  wire sleeping = state == power_mode_pkg::st_sleep ||
                  (state == power_mode_pkg::st_wake_ramp && !from_stop);
  // The MCU stays in reset while its supply is absent or ramping.
  assign mcu_reset_n = !(state == power_mode_pkg::st_reset ||
                         sleeping);
  assign mcu_supply_enable = !(state == power_mode_pkg::st_sleep);
  assign mcu_supply_from_main = !low_power;
  assign interface_supply_enable = !low_power;
  assign analog_supply_enable = !low_power;
  assign permanent_digital_supply_enable = 1'b1;
  assign low_power_clock_select = !(state == power_mode_pkg::st_normal ||
                     state == power_mode_pkg::st_stop_wait);
  assign undervoltage_interrupt =
    status_low[power_mode_pkg::undervoltage_flag_bit];

endmodule : power_mode_sequencer

//--- bench/power_mode_checker_assertions.sv
// Concurrent checks on the pins of the power mode sequencer.
`timescale 1ns/1ps
module power_mode_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mcu_supply_low,
  input wire logic battery_below_cranking,
  input wire logic die_link_clock_stopped,
  input wire logic mcu_reset_n,
  input wire logic mcu_supply_enable,
  input wire logic mcu_supply_from_main,
  input wire logic interface_supply_enable,
  input wire logic permanent_digital_supply_enable,
  input wire logic low_power_clock_select,
  input wire logic die_link_wake_interrupt,
  input wire logic undervoltage_interrupt,
  input wire logic watchdog_reset
);
  // ----------
  // Clocking
  // ----------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------
  // Properties
  // ----------
  // Two sync flops and the state register give three cycles of latency.
  property p_reset_hold;
    mcu_supply_low [*3] |=> !mcu_reset_n;
  endproperty
  a_reset_hold: assert property (p_reset_hold)
    else $error("reset not low");
  property p_sleep_cut;
    !mcu_supply_enable |-> !interface_supply_enable && !mcu_reset_n;
  endproperty
  a_sleep_cut: assert property (p_sleep_cut)
    else $error("sleep supply on");
  property p_low_power;
    !interface_supply_enable |->
      low_power_clock_select && permanent_digital_supply_enable;
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("low power clock");
  property p_ramp_clock;
    !mcu_supply_enable ##1 mcu_supply_enable |-> low_power_clock_select [*3];
  endproperty
  a_ramp_clock: assert property (p_ramp_clock)
    else $error("early clock switch");
  property p_wake_dog;
    !mcu_supply_enable ##1 mcu_supply_enable |-> ##[0:2] watchdog_reset;
  endproperty
  a_wake_dog: assert property (p_wake_dog)
    else $error("no watchdog reset");
  property p_dog_pulse;
    watchdog_reset |=> !watchdog_reset;
  endproperty
  a_dog_pulse: assert property (p_dog_pulse)
    else $error("long watchdog reset");
  property p_link_irq;
    die_link_wake_interrupt |-> mcu_supply_from_main ##1
      !die_link_wake_interrupt;
  endproperty
  a_link_irq: assert property (p_link_irq)
    else $error("bad wake interrupt");
  property p_stop_entry;
    $fell(interface_supply_enable) && mcu_supply_enable |->
      $past(die_link_clock_stopped, 2);
  endproperty
  a_stop_entry: assert property (p_stop_entry)
    else $error("stop with link clock");
  property p_undervoltage;
    battery_below_cranking [*3] |=> undervoltage_interrupt;
  endproperty
  a_undervoltage: assert property (p_undervoltage)
    else $error("no undervoltage irq");
endmodule : power_mode_checker

bind power_mode_sequencer power_mode_checker u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .mcu_supply_low(mcu_supply_low),
  .battery_below_cranking(battery_below_cranking),
  .die_link_clock_stopped(die_link_clock_stopped),
  .mcu_reset_n(mcu_reset_n),
  .mcu_supply_enable(mcu_supply_enable),
  .mcu_supply_from_main(mcu_supply_from_main),
  .interface_supply_enable(interface_supply_enable),
  .permanent_digital_supply_enable(permanent_digital_supply_enable),
  .low_power_clock_select(low_power_clock_select),
  .die_link_wake_interrupt(die_link_wake_interrupt),
  .undervoltage_interrupt(undervoltage_interrupt),
  .watchdog_reset(watchdog_reset)
);

//--- bench/mcu_die_model.sv
// Behavioural model of the companion microcontroller die and regulators.
`timescale 1ns/1ps
module mcu_die_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stop_request,
  input wire logic slow,
  input wire logic analog_supply_enable,
  input wire logic die_link_wake_interrupt,
  output logic die_link_clock_stopped,
  output logic regulators_ready
);
  logic [3:0] ramp;
  logic [1:0] stop_count;
  // Slow mode stretches the regulator ramp to shake out early releases.
  assign regulators_ready = ramp >= (slow ? 4'hc : 4'h1);
  // The link clock stops only a few cycles after the Stop command.
  assign die_link_clock_stopped = stop_request && stop_count == 2'h3;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp <= 4'h0;
      stop_count <= 2'h0;
    end else begin
      if (!analog_supply_enable) begin
        ramp <= 4'h0;
      end else if (ramp != 4'hf) begin
        ramp <= ramp + 4'h1;
      end
      if (!stop_request || die_link_wake_interrupt) begin
        stop_count <= 2'h0;
      end else if (stop_count != 2'h3) begin
        stop_count <= stop_count + 2'h1;
      end
    end
  end
endmodule : mcu_die_model

//--- bench/tb_power_mode_sequencer.sv
// Self-checking bench for the power mode sequencer.
`timescale 1ns/1ps
module tb_power_mode_sequencer;
  typedef struct {logic [31:0] exp; logic [31:0] mask; logic err;} note_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [2:0] rst_req;
  logic uv_low, crank_low, regs_ready, link_stopped, stop_req, slow;
  logic [5:0] wake_req;
  logic rst_n_mcu, sup_mcu, sup_main, sup_if, sup_an, sup_dig;
  logic lp_sel, link_irq, uv_irq, wd_rst;
  note_t notes[$];
  note_t nt;
  int err_total, n_tests, i, k;

  power_mode_sequencer #(.lifetime_bits(8)) u_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mcu_supply_low(rst_req[0]),
    .digital_supply_low(rst_req[1]), .external_reset_request(rst_req[2]),
    .battery_below_undervoltage(uv_low), .battery_below_cranking(crank_low),
    .regulators_ready(regs_ready), .die_link_clock_stopped(link_stopped),
    .wake_request(wake_req), .mcu_reset_n(rst_n_mcu),
    .mcu_supply_enable(sup_mcu), .mcu_supply_from_main(sup_main),
    .interface_supply_enable(sup_if), .analog_supply_enable(sup_an),
    .permanent_digital_supply_enable(sup_dig),
    .low_power_clock_select(lp_sel), .die_link_wake_interrupt(link_irq),
    .undervoltage_interrupt(uv_irq), .watchdog_reset(wd_rst));
  mcu_die_model u_mcu (.pclk(pclk), .presetn(presetn),
    .stop_request(stop_req), .slow(slow), .analog_supply_enable(sup_an),
    .die_link_wake_interrupt(link_irq),
    .die_link_clock_stopped(link_stopped), .regulators_ready(regs_ready));

  // ----------
  // Tasks
  // ----------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [31:0] mask, input logic err);
    notes.push_back('{exp, mask, err});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wrap_up();
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // ----------
  // Clock, read monitor and watchdog
  // ----------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      check("prdata", prdata & nt.mask, nt.exp & nt.mask);
      check("pslverr", {31'h0, pslverr}, {31'h0, nt.err});
    end
  end
  initial begin
    #(20 * 40000);
    err_total++;
    wrap_up();
  end

  // ----------
  // Scenarios
  // ----------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {rst_req, uv_low, crank_low, stop_req, slow, wake_req} = '0;
    err_total = 0;
    n_tests = 0;
    rnd = $urandom(83);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(power_mode_pkg::status_offset, 32'h1200, 32'hf7ff, 1'b0);
    rd(power_mode_pkg::wake_enable_offset, 32'h0, 32'h7f, 1'b0);
    rd(8'h14, 32'h0, 32'hffffffff, 1'b1);
    for (i = 0; i < 3; i++) begin
      rnd = $urandom;
      wr(power_mode_pkg::control_offset, 32'h4);
      wr(power_mode_pkg::peripheral_offset, {16'h0, rnd[15:0]});
      @(posedge pclk);
      rst_req[i] <= 1'b1;
      repeat (6) @(posedge pclk);
      check("reset low", {31'h0, rst_n_mcu}, 32'h0);
      rst_req <= 3'h0;
      repeat (6) @(posedge pclk);
      check("reset high", {31'h0, rst_n_mcu}, 32'h1);
      rd(power_mode_pkg::status_offset, 32'h1000 | (32'h1 << (8 + i)),
         32'hf700, 1'b0);
      rd(power_mode_pkg::control_offset, 32'h0, 32'h7, 1'b0);
      rd(power_mode_pkg::peripheral_offset, 32'h0, 32'hffff, 1'b0);
    end
    rnd = $urandom;
    wr(power_mode_pkg::peripheral_offset, {16'h0, rnd[15:0]});
    wr(power_mode_pkg::control_offset, 32'h1);
    wr(power_mode_pkg::peripheral_offset, {16'h0, ~rnd[15:0]});
    rd(power_mode_pkg::peripheral_offset, rnd, 32'hffff, 1'b0);
    rd(power_mode_pkg::status_offset, 32'h2000, 32'hf000, 1'b0);
    wr(power_mode_pkg::control_offset, 32'h0);
    rd(power_mode_pkg::status_offset, 32'h1000, 32'hf000, 1'b0);
    wr(power_mode_pkg::control_offset, 32'h3);
    rd(power_mode_pkg::control_offset, 32'h0, 32'h3, 1'b0);
    rd(power_mode_pkg::status_offset, 32'h1000, 32'hf000, 1'b0);
    wr(power_mode_pkg::control_offset, 32'h4);
    uv_low <= 1'b1;
    repeat (5) @(posedge pclk);
    check("uv above crank", {31'h0, uv_irq}, 32'h0);
    crank_low <= 1'b1;
    repeat (5) @(posedge pclk);
    check("uv below crank", {31'h0, uv_irq}, 32'h1);
    rd(power_mode_pkg::status_offset, 32'h80, 32'h80, 1'b0);
    {uv_low, crank_low} <= 2'h0;
    repeat (4) @(posedge pclk);
    wr(power_mode_pkg::control_offset, 32'h0);
    for (i = 0; i < 7; i++) begin
      rnd = $urandom;
      slow <= rnd[0];
      wr(power_mode_pkg::status_offset, 32'h7ff);
      wr(power_mode_pkg::wake_enable_offset, 32'h1 << i);
      wr(power_mode_pkg::control_offset, i[0] ? 32'h1 : 32'h2);
      stop_req <= i[0];
      for (k = 0; k < 600 && sup_if !== 1'b0; k++) @(posedge pclk);
      check("supplies", {28'h0, sup_mcu, sup_if, sup_an, sup_dig},
            {28'h0, i[0], 3'h1});
      if (i < 6) wake_req[i] <= 1'b1;
      for (k = 0; k < 600 && (i[0] ? link_irq : rst_n_mcu) !== 1'b1; k++)
        @(posedge pclk);
      stop_req <= 1'b0;
      wake_req <= 6'h0;
      check("clock select", {31'h0, lp_sel}, 32'h1);
      rd(power_mode_pkg::status_offset, 32'h6000 | (32'h1 << i),
         32'hf000 | (32'h1 << i), 1'b0);
      wr(power_mode_pkg::control_offset, 32'h0);
      rd(power_mode_pkg::status_offset, 32'h1000, 32'hf000, 1'b0);
    end
    wrap_up();
  end
endmodule : tb_power_mode_sequencer
